// *** design/tlia_arbiter.sv ***
// two-level interrupt arbiter with axi4-lite register slave
//
// Overview of operation
// [RULE_01] low-level routine preempted only by high level; high level never preempted.
// [RULE_02] both levels pending together: high level request wins.
// [RULE_03] same level pending together: fixed polling order picks one.
// [RULE_04] level select bit 5 is timer two, bit 3 timer one; one is high.
// [RULE_05] bit 4 serial, bit 2 external one, bit 0 external zero; one is high.
// [RULE_06] all source flags captured into samples in state 5 of each cycle.
// [RULE_07] samples are evaluated in the machine cycle after capture.
// [RULE_08] set and enabled sampled flag requests a hardware long call, unless blocked.
// [RULE_09] block request while same or higher level routine is in progress.
// [RULE_10] call pushes program counter then loads the source entry address.
// [RULE_11] each source has its own fixed entry address.
// [RULE_12] call saves only the program counter, nothing else.
// [RULE_13] return from service clears the serviced level flag; plain return does not.
// [RULE_14] enable register holds one bit per source and global gate at bit 7.
// [RULE_15] polling order: ext zero, timer zero, ext one, timer one, serial, timer two.
// [RULE_16] one in-progress flag per level, set when its call is issued.
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
module tlia_arbiter
  import tlia_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              reset,
  // interrupt source flags, bit order as the level select register
  input  wire logic [5:0]        src_flags,
  // cpu sequencer handshake
  output tlia_call_t             call_req,
  input  wire logic              call_ack,
  input  wire logic              ret_service,
  // axi4-lite slave
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   irq
);

  // ****************************************************************
  // functions
  // ****************************************************************
  // fixed entry address of a source
  function automatic logic [15:0] vec_of(input logic [2:0] src);
    case (src)
      3'h0:    vec_of = VEC_EXT_REQ_ZERO;
      3'h1:    vec_of = VEC_TIMER_ZERO;
      3'h2:    vec_of = VEC_EXT_REQ_ONE;
      3'h3:    vec_of = VEC_TIMER_ONE;
      3'h4:    vec_of = VEC_SERIAL;
      default: vec_of = VEC_TIMER_TWO;
    endcase
  endfunction : vec_of

  // first set bit in polling order, lowest index first
  function automatic logic [2:0] first_of(input logic [5:0] req);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = 3'(i);
      end
    end
    first_of = idx;
  endfunction : first_of

  // ****************************************************************
  // signals
  // ****************************************************************
  logic [7:0]  level_sel_q;
  logic [7:0]  src_en_q;
  logic [5:0]  sample_q;
  logic        busy_low_q;
  logic        busy_high_q;
  logic [2:0]  evt_q;
  logic [2:0]  evt_mask_q;
  tlia_state_t st_q;
  tlia_call_t  call_q;
  logic        capture_stb;
  logic        cycle_start;
  logic [5:0]  eligible;
  logic [5:0]  req_high;
  logic [5:0]  req_low;
  logic        pick_valid;
  logic        pick_level;
  logic [2:0]  pick_src;
  logic        ret_high;
  logic        ret_low;
  logic        wr_fire;
  logic        rd_fire;
  logic [7:0]  wr_addr_q;
  logic        wr_addr_ok_q;
  logic [31:0] wr_data_q;
  logic [3:0]  wr_strb_q;
  logic        wr_data_ok_q;
  logic [2:0]  evt_set;

  tlia_state_counter u_states (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .state_num   (),
    .capture_stb (capture_stb),
    .cycle_start (cycle_start)
  );

  // ****************************************************************
  // sampling and arbitration
  // ****************************************************************
  // [RULE_06] capture in state five
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sample_q <= 6'h00;
    end else if (capture_stb) begin
      sample_q <= src_flags;
    end
  end

  // [RULE_08] sampled, enabled and gated
  // [RULE_14] global gate blocks everything
  assign eligible = sample_q & src_en_q[5:0] & {6{src_en_q[POS_GLOBAL_GATE]}};
  // [RULE_04] level bits one for high
  // [RULE_05] same meaning for other sources
  assign req_high = eligible & level_sel_q[5:0];
  assign req_low  = eligible & ~level_sel_q[5:0];

  // [RULE_01] high running blocks all, low running blocks low
  // [RULE_09] block same or higher level
  // [RULE_02] high level wins
  always_comb begin
    pick_valid = 1'b0;
    pick_level = 1'b0;
    pick_src   = 3'h0;
    if (!busy_high_q && (req_high != 6'h00)) begin
      pick_valid = 1'b1;
      pick_level = 1'b1;
      // [RULE_03] polling order within level
      pick_src   = first_of(req_high);
    end else if (!busy_high_q && !busy_low_q && (req_low != 6'h00)) begin
      pick_valid = 1'b1;
      // [RULE_15] ext zero polled first
      pick_src   = first_of(req_low);
    end
  end

  // ****************************************************************
  // arbiter sequence: wait for a cycle start, poll, hold the call
  // ****************************************************************
  // [RULE_07] poll only in the cycle after capture
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q   <= ST_WAIT;
      call_q <= '0;
    end else begin
      case (st_q)
        ST_WAIT: begin
          if (cycle_start) begin
            st_q <= ST_POLL;
          end
        end
        ST_POLL: begin
          if (pick_valid) begin
            // [RULE_10] push pc, load entry address
            // [RULE_11] fixed vector per source
            // [RULE_12] only pc saved by sequencer
            call_q.valid  <= 1'b1;
            call_q.level  <= pick_level;
            call_q.source <= pick_src;
            call_q.vector <= vec_of(pick_src);
            st_q          <= ST_CALL;
          end else begin
            st_q <= ST_WAIT;
          end
        end
        ST_CALL: begin
          if (call_ack) begin
            call_q.valid <= 1'b0;
            st_q         <= ST_WAIT;
          end
        end
        default: st_q <= ST_WAIT;
      endcase
    end
  end

  assign call_req = call_q;

  // ****************************************************************
  // in-progress flags
  // ****************************************************************
  // return clears the highest level in progress
  assign ret_high = ret_service && busy_high_q;
  assign ret_low  = ret_service && !busy_high_q && busy_low_q;

  // [RULE_16] set when call_ack takes the call
  // [RULE_13] cleared only by return from service
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      busy_high_q <= 1'b0;
      busy_low_q  <= 1'b0;
    end else begin
      if (st_q == ST_CALL && call_ack && call_q.level) begin
        busy_high_q <= 1'b1;
      end else if (ret_high) begin
        busy_high_q <= 1'b0;
      end
      if (st_q == ST_CALL && call_ack && !call_q.level) begin
        busy_low_q <= 1'b1;
      end else if (ret_low) begin
        busy_low_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // event status and interrupt output
  // ****************************************************************
  assign evt_set = {ret_service,
                    st_q == ST_CALL && call_ack && call_q.level,
                    st_q == ST_CALL && call_ack && !call_q.level};

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      evt_q <= RST_EVT;
    end else if (wr_fire && wr_addr_q == ADDR_EVT_STATUS && wr_strb_q[0]) begin
      evt_q <= (evt_q & ~wr_data_q[2:0]) | evt_set;
    end else begin
      evt_q <= evt_q | evt_set;
    end
  end

  assign irq = |(evt_q & evt_mask_q);

  // ****************************************************************
  // axi4-lite write path
  // ****************************************************************
  // address and data may arrive in either order; held until response
  assign s_axi_awready = !wr_addr_ok_q && !s_axi_bvalid;
  assign s_axi_wready  = !wr_data_ok_q && !s_axi_bvalid;
  assign wr_fire       = wr_addr_ok_q && wr_data_ok_q && !s_axi_bvalid;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_addr_ok_q <= 1'b0;
      wr_addr_q    <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      wr_addr_ok_q <= 1'b1;
      wr_addr_q    <= s_axi_awaddr;
    end else if (wr_fire) begin
      wr_addr_ok_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_data_ok_q <= 1'b0;
      wr_data_q    <= 32'h0000_0000;
      wr_strb_q    <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wr_data_ok_q <= 1'b1;
      wr_data_q    <= s_axi_wdata;
      wr_strb_q    <= s_axi_wstrb;
    end else if (wr_fire) begin
      wr_data_ok_q <= 1'b0;
    end
  end

  // register writes, low byte lane only
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      level_sel_q <= RST_LEVEL_SELECT;
      src_en_q    <= RST_SOURCE_EN;
      evt_mask_q  <= RST_EVT;
    end else if (wr_fire && wr_strb_q[0]) begin
      case (wr_addr_q)
        ADDR_LEVEL_SELECT: level_sel_q <= wr_data_q[7:0] & LEVEL_SEL_MASK;
        ADDR_SOURCE_EN:    src_en_q    <= wr_data_q[7:0] & SOURCE_EN_MASK;
        ADDR_EVT_MASK:     evt_mask_q  <= wr_data_q[2:0];
        default:           ;
      endcase
    end
  end

  // write response, slverr for unmapped offsets
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_addr_q == ADDR_LEVEL_SELECT || wr_addr_q == ADDR_SOURCE_EN ||
                       wr_addr_q == ADDR_STATUS || wr_addr_q == ADDR_EVT_STATUS ||
                       wr_addr_q == ADDR_EVT_MASK) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // axi4-lite read path
  // ****************************************************************
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      case (s_axi_araddr)
        ADDR_LEVEL_SELECT: s_axi_rdata <= {24'h000000, level_sel_q};
        ADDR_SOURCE_EN:    s_axi_rdata <= {24'h000000, src_en_q};
        ADDR_STATUS:       s_axi_rdata <= {16'h0000, 2'h0, sample_q,
                                           5'h00, call_q.valid, busy_high_q, busy_low_q};
        ADDR_EVT_STATUS:   s_axi_rdata <= {29'h0000_0000, evt_q};
        ADDR_EVT_MASK:     s_axi_rdata <= {29'h0000_0000, evt_mask_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : tlia_arbiter

// *** design/tlia_pkg.sv ***
// package of constants and carrier types for the two-level interrupt arbiter
package tlia_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_LEVEL_SELECT = 8'h00;
  localparam logic [7:0] ADDR_SOURCE_EN    = 8'h04;
  localparam logic [7:0] ADDR_STATUS       = 8'h08;
  localparam logic [7:0] ADDR_EVT_STATUS   = 8'h0C;
  localparam logic [7:0] ADDR_EVT_MASK     = 8'h10;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int NUM_SRC           = 6;
  localparam int POS_EXT_REQ_ZERO  = 0;
  localparam int POS_TIMER_ZERO    = 1;
  localparam int POS_EXT_REQ_ONE   = 2;
  localparam int POS_TIMER_ONE     = 3;
  localparam int POS_SERIAL        = 4;
  localparam int POS_TIMER_TWO     = 5;
  localparam int POS_GLOBAL_GATE   = 7;
  localparam int POS_EVT_CALL_LOW  = 0;
  localparam int POS_EVT_CALL_HIGH = 1;
  localparam int POS_EVT_RETURN    = 2;

  // ****************************************************************
  // reset values and masks
  // ****************************************************************
  localparam logic [7:0]  RST_LEVEL_SELECT = 8'h00;
  localparam logic [7:0]  RST_SOURCE_EN    = 8'h00;
  localparam logic [7:0]  LEVEL_SEL_MASK   = 8'h3F;
  localparam logic [7:0]  SOURCE_EN_MASK   = 8'hBF;
  localparam logic [2:0]  RST_EVT          = 3'h0;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  // ****************************************************************
  // machine cycle timing: six states per machine cycle
  // ****************************************************************
  localparam int         STATES_PER_CYCLE = 6;
  localparam logic [2:0] CAPTURE_STATE    = 3'h5;
  localparam logic [2:0] LAST_STATE       = 3'h6;

  // ****************************************************************
  // fixed entry addresses, one per source in polling order
  // ****************************************************************
  localparam logic [15:0] VEC_EXT_REQ_ZERO = 16'h0003;
  localparam logic [15:0] VEC_TIMER_ZERO   = 16'h000B;
  localparam logic [15:0] VEC_EXT_REQ_ONE  = 16'h0013;
  localparam logic [15:0] VEC_TIMER_ONE    = 16'h001B;
  localparam logic [15:0] VEC_SERIAL       = 16'h0023;
  localparam logic [15:0] VEC_TIMER_TWO    = 16'h002B;

  // request to the cpu sequencer
  typedef struct packed {
    logic        valid;
    logic        level;
    logic [2:0]  source;
    logic [15:0] vector;
  } tlia_call_t;

  // arbiter states, gray along wait -> poll -> call
  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_POLL = 2'b01,
    ST_CALL = 2'b11
  } tlia_state_t;

endpackage : tlia_pkg

// *** design/tlia_state_counter.sv ***
// machine cycle state counter for the interrupt arbiter
`timescale 1ns/1ns
module tlia_state_counter
  import tlia_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  output logic [2:0]      state_num,
  output logic            capture_stb,
  output logic            cycle_start
);

  logic [2:0] count_q;

  // ****************************************************************
  // states 1..6 of each machine cycle
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      count_q <= 3'h1;
    end else if (count_q == LAST_STATE) begin
      count_q <= 3'h1;
    end else begin
      count_q <= count_q + 3'h1;
    end
  end

  assign state_num   = count_q;
  assign capture_stb = (count_q == CAPTURE_STATE);
  assign cycle_start = (count_q == LAST_STATE); // next edge opens a new cycle

endmodule : tlia_state_counter

// *** tb/tlia_arbiter_sva.sv ***
// checker for the arbiter call link and its register bus
`timescale 1ns/1ns
module tlia_arbiter_chk
  import tlia_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire tlia_call_t  call_req,
  input wire logic        call_ack,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  // ****************
  // call link
  // ****************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  call_hold_a: assert property (
    call_req.valid && !call_ack |=> call_req.valid && $stable(call_req)) else $error("call moved");
  call_drop_a: assert property (
    call_req.valid && call_ack |=> !call_req.valid) else $error("call kept after ack");
  // entry address is fixed by source: 0x0003 plus eight per slot
  vector_map_a: assert property (
    call_req.valid |-> call_req.vector == {10'h000, call_req.source, 3'h3}) else $error("bad vector");
  source_range_a: assert property (
    call_req.valid |-> call_req.source <= 3'h5) else $error("bad source");
  // ****************
  // register bus
  // ****************
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp}))
    else $error("read answer moved");
  ar_block_a: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  aw_block_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  b_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("no write answer");
  r_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
  // main scenarios
  cover property (call_req.valid && call_ack && call_req.level);
  cover property (call_req.valid && call_ack && !call_req.level);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == RESP_SLVERR);
endmodule : tlia_arbiter_chk

bind tlia_arbiter tlia_arbiter_chk chk_u (.sys_clk(sys_clk), .reset(reset), .call_req(call_req),
  .call_ack(call_ack), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));

// *** tb/tlia_cpu_model.sv ***
// cpu sequencer model answering the arbiter call link
`timescale 1ns/1ns
module tlia_cpu_model
  import tlia_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire tlia_call_t call_req,
  input  wire logic [1:0] ack_dly,
  output logic            call_ack,
  output logic            ret_service
);
  int          n_calls;
  int          wait_q;
  tlia_call_t  last_call;
  logic [15:0] pc_q;
  logic [15:0] stack_q [$];

  // ****************
  // call acceptance
  // ****************
  // ack after a chosen delay so a slow sequencer is exercised too
  always @(posedge sys_clk) begin
    if (reset) begin
      call_ack <= 1'b0;
      wait_q   <= 0;
      n_calls  <= 0;
      pc_q     <= 16'h0100;
    end else begin
      call_ack <= 1'b0;
      if (call_req.valid && call_ack) begin
        stack_q.push_back(pc_q);
        pc_q      <= call_req.vector;
        last_call <= call_req;
        n_calls   <= n_calls + 1;
        wait_q    <= 0;
      end else if (call_req.valid && wait_q >= ack_dly) begin
        call_ack <= 1'b1;
      end else if (call_req.valid) begin
        wait_q <= wait_q + 1;
      end
    end
  end

  // one-cycle return pulse; restores the saved counter
  task automatic do_return();
    ret_service <= 1'b1;
    if (stack_q.size() > 0) pc_q <= stack_q.pop_back();
    @(posedge sys_clk);
    ret_service <= 1'b0;
    @(posedge sys_clk);
  endtask : do_return

  // defined levels before the first reset edge
  initial begin
    ret_service = 1'b0;
  end
endmodule : tlia_cpu_model

// *** tb/tb_two_level_interrupt_arbiter.sv ***
// testbench for the two-level interrupt arbiter
`timescale 1ns/1ns
module tb_two_level_interrupt_arbiter;
  import tlia_pkg::*;
  logic        sys_clk = 1'b0, reset = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, call_ack, ret_service, irq;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [5:0]  flags = 6'h00;
  logic [1:0]  ack_dly = 2'h0, bresp, rresp, rsp;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [3:0]  wstrb = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, rd_data;
  tlia_call_t  call_req;
  int          errors = 0, n_tests = 0, calls_done = 0;
  logic [15:0] vecs [6] = '{VEC_EXT_REQ_ZERO, VEC_TIMER_ZERO, VEC_EXT_REQ_ONE,
                            VEC_TIMER_ONE, VEC_SERIAL, VEC_TIMER_TWO};

  tlia_arbiter dut_u (.sys_clk(sys_clk), .reset(reset), .src_flags(flags), .call_req(call_req),
    .call_ack(call_ack), .ret_service(ret_service), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq));
  tlia_cpu_model cpu_u (.sys_clk(sys_clk), .reset(reset), .call_req(call_req),
    .ack_dly(ack_dly), .call_ack(call_ack), .ret_service(ret_service));

  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;

  // ****************
  // tasks
  // ****************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // write: both halves offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    // no local limit: only the watchdog ends a wait
    forever begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin rsp = bresp; break; end
    end
    bready <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  // read: rready raised late so the slave must hold its answer
  task automatic rd(input logic [7:0] a);
    araddr <= a; arvalid <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin rd_data = rdata; rsp = rresp; break; end
      if (rvalid) rready <= 1'b1;
    end
    rready <= 1'b0;
    @(posedge sys_clk);
  endtask : rd

  // wait for one taken call, compare it, then drop its flag
  // counts against calls already consumed: a call may land during a preceding access
  task automatic expect_call(input int s, input logic lv);
    while (cpu_u.n_calls <= calls_done) @(posedge sys_clk);
    calls_done++;
    chk("source", 32'(cpu_u.last_call.source), 32'(s));
    chk("level", 32'(cpu_u.last_call.level), 32'(lv));
    chk("vector", 32'(cpu_u.last_call.vector), 32'(vecs[s]));
    flags[s] <= 1'b0;
    @(posedge sys_clk);
  endtask : expect_call

  task automatic no_call();
    repeat (24) @(posedge sys_clk);
    chk("calls", cpu_u.n_calls, calls_done);
  endtask : no_call

  task automatic give_verdict();
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  // ****************
  // sequence
  // ****************
  initial begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd(ADDR_LEVEL_SELECT); chk("lvl rst", rd_data, 32'(RST_LEVEL_SELECT));
    chk("rresp", 32'(rsp), 32'(RESP_OKAY));
    rd(ADDR_SOURCE_EN); chk("en rst", rd_data, 32'(RST_SOURCE_EN));
    wr(ADDR_LEVEL_SELECT, 32'hFF); rd(ADDR_LEVEL_SELECT); chk("lvl", rd_data, 32'h3F);
    wr(ADDR_LEVEL_SELECT, 32'h00);
    chk("bresp", 32'(rsp), 32'(RESP_OKAY));
    // gate closed: flags sampled but nothing called
    wr(ADDR_SOURCE_EN, 32'h3F); flags <= 6'h3F;
    no_call();
    rd(ADDR_STATUS); chk("samples", 32'(rd_data[13:8]), 32'h3F);
    wr(ADDR_SOURCE_EN, 32'hFF); rd(ADDR_SOURCE_EN); chk("en", rd_data, 32'hBF);
    // all low: polling order, blocked while busy, freed by return
    for (int n = 0; n < NUM_SRC; n++) begin
      expect_call(n, 1'b0);
      if (n == 0) no_call();
      cpu_u.do_return();
    end
    // timer two high against ext zero low, with a slow sequencer
    ack_dly <= 2'h3; wr(ADDR_LEVEL_SELECT, 32'h20); flags <= 6'h21;
    expect_call(POS_TIMER_TWO, 1'b1);
    no_call();
    rd(ADDR_STATUS); chk("busy", 32'(rd_data[1:0]), 32'h2);
    cpu_u.do_return();
    expect_call(POS_EXT_REQ_ZERO, 1'b0);
    flags[POS_TIMER_TWO] <= 1'b1;
    expect_call(POS_TIMER_TWO, 1'b1);
    rd(ADDR_STATUS); chk("busy", 32'(rd_data[1:0]), 32'h3);
    cpu_u.do_return();
    rd(ADDR_STATUS); chk("busy", 32'(rd_data[1:0]), 32'h1);
    cpu_u.do_return();
    // events, mask and clear
    rd(ADDR_EVT_STATUS); chk("evt", 32'(rd_data[2:0]), 32'h7);
    chk("irq", 32'(irq), 32'h0);
    wr(ADDR_EVT_MASK, 32'h1); chk("irq", 32'(irq), 32'h1);
    wr(ADDR_EVT_STATUS, 32'h1); chk("irq", 32'(irq), 32'h0);
    rd(ADDR_EVT_STATUS); chk("evt", 32'(rd_data[2:0]), 32'h6);
    // unmapped place
    rd(8'h20); chk("resp", 32'(rsp), 32'(RESP_SLVERR)); chk("data", rd_data, 32'h0);
    wr(8'h24, 32'h1); chk("resp", 32'(rsp), 32'(RESP_SLVERR));
    give_verdict();
  end

  // watchdog, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    give_verdict();
  end
endmodule : tb_two_level_interrupt_arbiter
